// ===== src/splc_pkg.sv
package splc_pkg;

  // ----------------------------------------
  // Clock and bus widths
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 17;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_TT = 8'h04;
  localparam logic [7:0] REG_IDLE = 8'h08;
  localparam logic [7:0] REG_SID = 8'h0c;
  localparam logic [7:0] REG_TXD = 8'h10;
  localparam logic [7:0] REG_RXD = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int CFG_PAR_LSB = 3;
  localparam int CFG_STOP2_BIT = 5;
  localparam int CFG_DATA7_BIT = 6;
  localparam logic [6:0] CFG_RST = 7'h0e;
  localparam logic [7:0] TT_RST = 8'h00;
  localparam logic [5:0] IDLE_RST = 6'h0a;
  localparam logic [26:0] SID_RST = 27'h6a00001;
  localparam int SID_LEN_LSB = 24;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_PAR_ERR = 2;
  localparam int ST_FRM_ERR = 3;
  localparam int ST_SESSION = 4;
  localparam int ST_LOST = 5;
  localparam int ST_ID_OK = 6;
  localparam int ST_OVERRUN = 7;
  localparam logic [7:0] STAT_RST = 8'h40;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TICKS_PER_SEC = 7'h64;

  typedef enum logic [5:0] {
    SPLC_TX_IDLE = 6'h01, SPLC_TX_TURN = 6'h02, SPLC_TX_START = 6'h04,
    SPLC_TX_DATA = 6'h08, SPLC_TX_PAR = 6'h10, SPLC_TX_STOP = 6'h20
  } splc_tx_st_t;

  typedef enum logic [4:0] {
    SPLC_RX_IDLE = 5'h01, SPLC_RX_START = 5'h02, SPLC_RX_DATA = 5'h04,
    SPLC_RX_PAR = 5'h08, SPLC_RX_STOP = 5'h10
  } splc_rx_st_t;

  function automatic logic [CNT_W-1:0] splc_bit_div(input logic [2:0] sel);
    case (sel)
      3'h0: splc_bit_div = CNT_W'(CLK_HZ / 300);
      3'h1: splc_bit_div = CNT_W'(CLK_HZ / 600);
      3'h2: splc_bit_div = CNT_W'(CLK_HZ / 1200);
      3'h3: splc_bit_div = CNT_W'(CLK_HZ / 2400);
      3'h4: splc_bit_div = CNT_W'(CLK_HZ / 4800);
      3'h5: splc_bit_div = CNT_W'(CLK_HZ / 9600);
      default: splc_bit_div = CNT_W'(CLK_HZ / 19200);
    endcase
  endfunction : splc_bit_div

  function automatic logic splc_parity(input logic [7:0] d, input logic data7, input logic [1:0] mode);
    splc_parity = ^{d[7] & ~data7, d[6:0]} ^ (mode == PAR_ODD);
  endfunction : splc_parity

  function automatic logic [7:0] splc_sid_ascii(input logic [26:0] sid, input logic [2:0] idx);
    logic [3:0] nib;
    nib = sid[5'(23 - 4 * idx) -: 4];
    splc_sid_ascii = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
  endfunction : splc_sid_ascii

endpackage : splc_pkg

// ===== src/splc_port.sv
`timescale 1ns/1ns
// Function
// - Bit rates 300 to 19200, default 19200.
// - Odd, even or no parity, default odd.
// - One or two stop bits, default one.
// - Seven or eight data bits, default eight.
// - Modem turnaround wait in hundredths; zero none.
// - Idle timeout drops session, awaits new connection.
// - Station identifier: up to six hex chars, first A-F.
// - Identifier addresses module on multi-drop links.
module splc_port #(
  parameter int TICK_CYC = splc_pkg::TICK_CYC_DEF
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port.
  input wire logic [splc_pkg::ADDR_W-1:0] addr,
  input wire logic [splc_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [splc_pkg::DATA_W-1:0] rd_data,
  // Serial pins and session flag.
  input wire logic rxd,
  output logic txd,
  output logic rts,
  output logic session_active
);
  import splc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [6:0] cfg_ff, nxt_cfg;
  logic [7:0] tt_ff, nxt_tt;
  logic [5:0] idle_ff, nxt_idle;
  logic [26:0] sid_ff, nxt_sid;
  logic [7:0] rx_data_ff, nxt_rx_data;
  logic [7:0] stat_ff, nxt_stat;
  logic [2:0] sid_idx_ff, nxt_sid_idx;
  logic [12:0] idle_ticks_ff, nxt_idle_ticks;
  logic [12:0] idle_lim;
  logic [31:0] pre_ff, nxt_pre;
  logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
  logic rxd_meta_ff, rxd_s2_ff, rxd_s3_ff, rxd_ff, nxt_rxd;
  splc_tx_st_t tx_st_ff, nxt_tx_st;
  logic [CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;
  logic [2:0] tx_bit_ff, nxt_tx_bit;
  logic [7:0] tx_byte_ff, nxt_tx_byte;
  logic [8:0] tt_cnt_ff, nxt_tt_cnt;
  logic txd_ff, nxt_txd, rts_ff, nxt_rts;
  splc_rx_st_t rx_st_ff, nxt_rx_st;
  logic [CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
  logic [2:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic rx_perr_ff, nxt_rx_perr;
  logic rx_done, rx_ferr, tick, tx_go;
  logic [CNT_W-1:0] bit_div;
  logic [2:0] last_bit, sid_len;
  logic [1:0] par_mode;

  assign bit_div = splc_bit_div(cfg_ff[2:0]);
  assign par_mode = cfg_ff[CFG_PAR_LSB +: 2];
  assign last_bit = cfg_ff[CFG_DATA7_BIT] ? 3'h6 : 3'h7;
  assign sid_len = sid_ff[SID_LEN_LSB +: 3];
  assign idle_lim = 13'(idle_ff) * 13'(TICKS_PER_SEC);
  assign tick = (pre_ff == 32'(TICK_CYC - 1));
  assign tx_go = wr_en && (addr == REG_TXD) && (tx_st_ff == SPLC_TX_IDLE);
  assign rd_data = rd_data_ff;
  assign txd = txd_ff;
  assign rts = rts_ff;
  assign session_active = stat_ff[ST_SESSION];

  // ----------------------------------------
  // Registers, status and session
  // ----------------------------------------
  always_comb
  begin
    nxt_cfg = cfg_ff;
    nxt_tt = tt_ff;
    nxt_idle = idle_ff;
    nxt_sid = sid_ff;
    nxt_rx_data = rx_data_ff;
    nxt_stat = stat_ff;
    nxt_sid_idx = sid_idx_ff;
    nxt_idle_ticks = idle_ticks_ff;
    nxt_pre = tick ? 32'h0 : pre_ff + 32'h1;
    nxt_rd_data = '0;
    if (wr_en)
    begin
      if (addr == REG_CFG)
        nxt_cfg = wr_data[6:0];
      else if (addr == REG_TT)
        nxt_tt = wr_data[7:0];
      else if (addr == REG_IDLE)
        nxt_idle = wr_data[5:0];
      else if (addr == REG_SID)
        nxt_sid = wr_data[26:0];
    end
    if (rd_en)
    begin
      if (addr == REG_CFG)
        nxt_rd_data = {25'h0, cfg_ff};
      else if (addr == REG_TT)
        nxt_rd_data = {24'h0, tt_ff};
      else if (addr == REG_IDLE)
        nxt_rd_data = {26'h0, idle_ff};
      else if (addr == REG_SID)
        nxt_rd_data = {5'h0, sid_ff};
      else if (addr == REG_RXD)
        nxt_rd_data = {24'h0, rx_data_ff};
      else if (addr == REG_STAT)
        nxt_rd_data = {24'h0, stat_ff};
      if (addr == REG_RXD)
        nxt_stat[ST_RX_VALID] = 1'b0;
      if (addr == REG_STAT)
        nxt_stat[ST_LOST] = 1'b0;
      if (addr == REG_STAT)
        nxt_stat[ST_OVERRUN] = 1'b0;
    end
    nxt_stat[ST_TX_BUSY] = (nxt_tx_st != SPLC_TX_IDLE);
    nxt_stat[ST_ID_OK] = (nxt_sid[26:24] <= 3'h6) &&
      ((nxt_sid[26:24] == 3'h0) || (nxt_sid[23:20] >= 4'ha));
    if (stat_ff[ST_SESSION] && tick)
      nxt_idle_ticks = idle_ticks_ff + 13'h1;
    if (stat_ff[ST_SESSION] && tick && !rx_done && (idle_ticks_ff >= idle_lim))
    begin
      nxt_stat[ST_SESSION] = 1'b0;
      nxt_stat[ST_LOST] = 1'b1;
      nxt_sid_idx = 3'h0;
    end
    if (rx_done)
    begin
      nxt_rx_data = rx_sh_ff;
      nxt_stat[ST_OVERRUN] = stat_ff[ST_OVERRUN] | stat_ff[ST_RX_VALID];
      nxt_stat[ST_RX_VALID] = 1'b1;
      nxt_stat[ST_PAR_ERR] = rx_perr_ff;
      nxt_stat[ST_FRM_ERR] = rx_ferr;
      nxt_idle_ticks = 13'h0;
      if (!stat_ff[ST_SESSION])
      begin
        if (sid_len == 3'h0)
          nxt_stat[ST_SESSION] = 1'b1;
        else if (rx_sh_ff == splc_sid_ascii(sid_ff, sid_idx_ff))
        begin
          nxt_sid_idx = sid_idx_ff + 3'h1;
          if (sid_idx_ff + 3'h1 == sid_len)
          begin
            nxt_stat[ST_SESSION] = 1'b1;
            nxt_sid_idx = 3'h0;
          end
        end
        else
          nxt_sid_idx = 3'h0;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  always_comb
  begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_byte = tx_byte_ff;
    nxt_txd = txd_ff;
    nxt_rts = rts_ff;
    nxt_tt_cnt = tt_cnt_ff;
    if (tx_st_ff != SPLC_TX_IDLE && tx_st_ff != SPLC_TX_TURN)
      nxt_tx_cnt = tx_cnt_ff - CNT_W'(1);
    case (tx_st_ff)
      SPLC_TX_IDLE:
        if (tx_go)
        begin
          nxt_tx_byte = wr_data[7:0];
          nxt_rts = 1'b1;
          nxt_tt_cnt = 9'h0;
          nxt_tx_st = SPLC_TX_TURN;
          if (tt_ff == 8'h0)
          begin
            nxt_tx_st = SPLC_TX_START;
            nxt_txd = 1'b0;
            nxt_tx_cnt = bit_div;
          end
        end
      SPLC_TX_TURN:
      begin
        if (tick)
          nxt_tt_cnt = tt_cnt_ff + 9'h1;
        if (tt_cnt_ff > {1'b0, tt_ff})
        begin
          nxt_tx_st = SPLC_TX_START;
          nxt_txd = 1'b0;
          nxt_tx_cnt = bit_div;
        end
      end
      SPLC_TX_START:
        if (tx_cnt_ff == CNT_W'(1))
        begin
          nxt_tx_st = SPLC_TX_DATA;
          nxt_tx_bit = 3'h0;
          nxt_txd = tx_byte_ff[0];
          nxt_tx_cnt = bit_div;
        end
      SPLC_TX_DATA:
        if (tx_cnt_ff == CNT_W'(1))
        begin
          nxt_tx_cnt = bit_div;
          nxt_tx_bit = tx_bit_ff + 3'h1;
          nxt_txd = tx_byte_ff[nxt_tx_bit];
          if (tx_bit_ff == last_bit)
          begin
            nxt_tx_bit = 3'h0;
            nxt_tx_st = (par_mode == PAR_ODD || par_mode == PAR_EVEN) ? SPLC_TX_PAR : SPLC_TX_STOP;
            nxt_txd = (nxt_tx_st == SPLC_TX_PAR) ?
              splc_parity(tx_byte_ff, cfg_ff[CFG_DATA7_BIT], par_mode) : 1'b1;
          end
        end
      SPLC_TX_PAR:
        if (tx_cnt_ff == CNT_W'(1))
        begin
          nxt_tx_st = SPLC_TX_STOP;
          nxt_txd = 1'b1;
          nxt_tx_cnt = bit_div;
        end
      SPLC_TX_STOP:
        if (tx_cnt_ff == CNT_W'(1))
        begin
          nxt_tx_cnt = bit_div;
          nxt_tx_bit = 3'h1;
          if (!cfg_ff[CFG_STOP2_BIT] || tx_bit_ff != 3'h0)
          begin
            nxt_tx_st = SPLC_TX_IDLE;
            nxt_rts = 1'b0;
            nxt_tx_bit = 3'h0;
          end
        end
      default:
        nxt_tx_st = SPLC_TX_IDLE;
    endcase
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  always_comb
  begin
    nxt_rxd = (rxd_s2_ff == rxd_s3_ff) ? rxd_s3_ff : rxd_ff;
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff - CNT_W'(1);
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_perr = rx_perr_ff;
    rx_done = 1'b0;
    rx_ferr = 1'b0;
    case (rx_st_ff)
      SPLC_RX_IDLE:
        if (!rxd_ff)
        begin
          nxt_rx_st = SPLC_RX_START;
          nxt_rx_cnt = bit_div >> 1;
          nxt_rx_sh = 8'h0;
          nxt_rx_bit = 3'h0;
          nxt_rx_perr = 1'b0;
        end
      SPLC_RX_START:
        if (rx_cnt_ff == CNT_W'(1))
        begin
          nxt_rx_st = rxd_ff ? SPLC_RX_IDLE : SPLC_RX_DATA;
          nxt_rx_cnt = bit_div;
        end
      SPLC_RX_DATA:
        if (rx_cnt_ff == CNT_W'(1))
        begin
          nxt_rx_sh[rx_bit_ff] = rxd_ff;
          nxt_rx_bit = rx_bit_ff + 3'h1;
          nxt_rx_cnt = bit_div;
          if (rx_bit_ff == last_bit)
            nxt_rx_st = (par_mode == PAR_ODD || par_mode == PAR_EVEN) ? SPLC_RX_PAR : SPLC_RX_STOP;
        end
      SPLC_RX_PAR:
        if (rx_cnt_ff == CNT_W'(1))
        begin
          nxt_rx_perr = rxd_ff != splc_parity(rx_sh_ff, cfg_ff[CFG_DATA7_BIT], par_mode);
          nxt_rx_st = SPLC_RX_STOP;
          nxt_rx_cnt = bit_div;
        end
      SPLC_RX_STOP:
        if (rx_cnt_ff == CNT_W'(1))
        begin
          rx_done = 1'b1;
          rx_ferr = !rxd_ff;
          nxt_rx_st = SPLC_RX_IDLE;
        end
      default:
        nxt_rx_st = SPLC_RX_IDLE;
    endcase
  end

  // ----------------------------------------
  // Flip-flops
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cfg_ff <= CFG_RST;
      tt_ff <= TT_RST;
      idle_ff <= IDLE_RST;
      sid_ff <= SID_RST;
      rx_data_ff <= '0;
      stat_ff <= STAT_RST;
      sid_idx_ff <= '0;
      idle_ticks_ff <= '0;
      pre_ff <= '0;
      rd_data_ff <= '0;
      {rxd_meta_ff, rxd_s2_ff, rxd_s3_ff, rxd_ff} <= 4'hf;
      tx_st_ff <= SPLC_TX_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_byte_ff <= '0;
      tt_cnt_ff <= '0;
      txd_ff <= 1'b1;
      rts_ff <= 1'b0;
      rx_st_ff <= SPLC_RX_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_perr_ff <= 1'b0;
    end
    else if (ce)
    begin
      cfg_ff <= nxt_cfg;
      tt_ff <= nxt_tt;
      idle_ff <= nxt_idle;
      sid_ff <= nxt_sid;
      rx_data_ff <= nxt_rx_data;
      stat_ff <= nxt_stat;
      sid_idx_ff <= nxt_sid_idx;
      idle_ticks_ff <= nxt_idle_ticks;
      pre_ff <= nxt_pre;
      rd_data_ff <= nxt_rd_data;
      {rxd_meta_ff, rxd_s2_ff, rxd_s3_ff, rxd_ff} <= {rxd, rxd_meta_ff, rxd_s2_ff, nxt_rxd};
      tx_st_ff <= nxt_tx_st;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_byte_ff <= nxt_tx_byte;
      tt_cnt_ff <= nxt_tt_cnt;
      txd_ff <= nxt_txd;
      rts_ff <= nxt_rts;
      rx_st_ff <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_perr_ff <= nxt_rx_perr;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_bit_len;
    (ce && tx_st_ff == SPLC_TX_DATA && tx_cnt_ff == CNT_W'(1)) |=> (tx_cnt_ff == bit_div) || !ce;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("Bit period not reloaded.");
  property p_par;
    (tx_st_ff == SPLC_TX_PAR) |-> txd_ff == splc_parity(tx_byte_ff, cfg_ff[CFG_DATA7_BIT], par_mode);
  endproperty
  a_par: assert property (p_par) else $error("Wrong parity bit.");
  property p_stop;
    (tx_st_ff == SPLC_TX_STOP) |-> txd_ff && tx_bit_ff <= {2'h0, cfg_ff[CFG_STOP2_BIT]};
  endproperty
  a_stop: assert property (p_stop) else $error("Bad stop bit.");
  property p_width;
    (tx_st_ff == SPLC_TX_DATA) |-> tx_bit_ff <= last_bit;
  endproperty
  a_width: assert property (p_width) else $error("Too many data bits.");
  property p_turn;
    (tx_st_ff == SPLC_TX_TURN) |-> rts_ff && tt_ff != 8'h0 && txd_ff;
  endproperty
  a_turn: assert property (p_turn) else $error("Turnaround without modem.");
  property p_idle;
    (ce && stat_ff[ST_SESSION] && tick && !rx_done && idle_ticks_ff >= idle_lim)
      |=> !stat_ff[ST_SESSION] && stat_ff[ST_LOST];
  endproperty
  a_idle: assert property (p_idle) else $error("Idle timeout missed.");
  property p_id;
    stat_ff[ST_ID_OK] |-> (sid_len == 3'h0) || (sid_ff[23:20] >= 4'ha && sid_len <= 3'h6);
  endproperty
  a_id: assert property (p_id) else $error("Invalid identifier accepted.");
  property p_sel;
    (ce && !stat_ff[ST_SESSION] && rx_done && sid_len != 3'h0 && rx_sh_ff != splc_sid_ascii(sid_ff, sid_idx_ff))
      |=> !stat_ff[ST_SESSION];
  endproperty
  a_sel: assert property (p_sel) else $error("Session without address.");
  property p_frame;
    (tx_st_ff == SPLC_TX_DATA) |-> txd_ff == tx_byte_ff[tx_bit_ff];
  endproperty
  a_frame: assert property (p_frame) else $error("Data bit out of order.");
  property p_start;
    (tx_st_ff == SPLC_TX_START) |-> !txd_ff && rts_ff;
  endproperty
  a_start: assert property (p_start) else $error("Start bit not low.");

  c_tx_frame: cover property (tx_st_ff == SPLC_TX_STOP ##1 tx_st_ff == SPLC_TX_IDLE);
  c_rx_char: cover property (rx_done && !rx_ferr);
  c_session: cover property (!stat_ff[ST_SESSION] ##1 stat_ff[ST_SESSION]);
  c_timeout: cover property ($rose(stat_ff[ST_LOST]));

endmodule : splc_port

// ===== test/splc_host.sv
`timescale 1ns/1ns
module splc_host (
  // Clock.
  input wire logic ref_clk,
  // Serial lines seen from the host side.
  input wire logic txd,
  input wire logic rts,
  output logic h_tx
);
  import splc_pkg::*;

  initial h_tx = 1'b1;

  // Sends one character in the agreed format; flip inverts the parity bit.
  task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par, input int div, input logic flip);
    logic p;
    p = ^(d & ((nb == 7) ? 8'h7f : 8'hff)) ^ (par == PAR_ODD) ^ flip;
    @(posedge ref_clk);
    h_tx <= 1'b0;
    repeat (div) @(posedge ref_clk);
    for (int i = 0; i < nb; i++)
    begin
      h_tx <= d[i];
      repeat (div) @(posedge ref_clk);
    end
    if (par == PAR_ODD || par == PAR_EVEN)
    begin
      h_tx <= p;
      repeat (div) @(posedge ref_clk);
    end
    h_tx <= 1'b1;
    repeat (div) @(posedge ref_clk);
  endtask : send

  // Receives one character; ok collects start level, stop levels and the transmit request.
  task automatic recv(output logic [7:0] d, output logic p, output logic ok, output int waited,
                      input int nb, input logic [1:0] par, input int nstop, input int div);
    d = 8'h00;
    p = 1'b0;
    waited = 0;
    while (txd !== 1'b0 && waited < 100000)
    begin
      @(posedge ref_clk);
      waited++;
    end
    repeat (div / 2) @(posedge ref_clk);
    ok = (txd === 1'b0) && (rts === 1'b1);
    for (int i = 0; i < nb; i++)
    begin
      repeat (div) @(posedge ref_clk);
      d[i] = txd;
    end
    if (par == PAR_ODD || par == PAR_EVEN)
    begin
      repeat (div) @(posedge ref_clk);
      p = txd;
    end
    for (int i = 0; i < nstop; i++)
    begin
      repeat (div) @(posedge ref_clk);
      ok = ok && (txd === 1'b1) && (rts === 1'b1);
    end
  endtask : recv

endmodule : splc_host

// ===== test/tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  import splc_pkg::*;

  localparam int TICK = 20;
  localparam int D19 = CLK_HZ / 19200;
  localparam int D96 = CLK_HZ / 9600;
  localparam int LIMIT = 95000;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic rxd;
  logic txd;
  logic rts;
  logic session_active;
  logic [31:0] rv;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int w;
  logic [7:0] ra [6] = '{REG_CFG, REG_TT, REG_IDLE, REG_SID, REG_STAT, 8'h20};
  logic [31:0] re [6] = '{32'h0e, 32'h0, 32'h0a, 32'h06a00001, 32'h40, 32'h0};
  logic [31:0] sid [4] = '{32'h01b00000, 32'h01000000, 32'h07a00000, 32'h0};
  logic ok_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  splc_port #(.TICK_CYC(TICK)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rxd(rxd), .txd(txd),
    .rts(rts), .session_active(session_active));

  splc_host host (.ref_clk(ref_clk), .txd(txd), .rts(rts), .h_tx(rxd));

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    v = rd_data;
  endtask : rd

  // Sends one character through the port and checks it on the line; twice adds a write while busy.
  task automatic tx_frame(input logic [6:0] cfg, input logic [7:0] d, input int nb, input logic [1:0] par,
                          input int nstop, input int div, input logic twice);
    logic [7:0] got;
    logic pb;
    logic ok;
    logic [7:0] msk;
    msk = (nb == 7) ? 8'h7f : 8'hff;
    wr(REG_CFG, {25'h0, cfg});
    fork
      host.recv(got, pb, ok, w, nb, par, nstop, div);
      begin
        wr(REG_TXD, {24'h0, d});
        if (twice)
          wr(REG_TXD, 32'h0000005a);
      end
    join
    `CHK(got, d & msk)
    if (par != 2'h0)
      `CHK(pb, ^(d & msk) ^ (par == PAR_ODD))
    `CHK(ok, 1'b1)
    repeat (div / 2 + 4) @(posedge ref_clk);
    `CHK({rts, txd}, 2'b01)
    rd(REG_STAT, rv);
    `CHK(rv[ST_TX_BUSY], 1'b0)
  endtask : tx_frame

  initial
  begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], rv);
      `CHK(rv, re[i])
    end
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(REG_TT, 32'h5);
    ce <= 1'b1;
    rd(REG_TT, rv);
    `CHK(rv, 32'h0)
    $display("test reset_values done");
    tx_frame(7'h0e, 8'ha5, 8, PAR_ODD, 1, D19, 1'b0);
    `CHK(w <= 4, 1'b1)
    tx_frame(7'h76, 8'hd3, 7, PAR_EVEN, 2, D19, 1'b0);
    tx_frame(7'h05, 8'h3c, 8, 2'h0, 1, D96, 1'b0);
    $display("test tx_formats done");
    wr(REG_TT, 32'h2);
    tx_frame(7'h0e, 8'h81, 8, PAR_ODD, 1, D19, 1'b1);
    `CHK((w >= 2 * TICK) && (w <= 3 * TICK + 6), 1'b1)
    wr(REG_TT, 32'h0);
    $display("test turnaround done");
    wr(REG_SID, 32'h01b00000);
    wr(REG_IDLE, 32'h1);
    host.send(8'h31, 8, PAR_ODD, D19, 1'b1);
    repeat (4) @(posedge ref_clk);
    rd(REG_STAT, rv);
    `CHK(rv[4:1], 4'h3)
    rd(REG_RXD, rv);
    `CHK(rv, 32'h31)
    rd(REG_STAT, rv);
    `CHK(rv[ST_RX_VALID], 1'b0)
    host.send(8'h42, 8, PAR_ODD, D19, 1'b0);
    repeat (4) @(posedge ref_clk);
    `CHK(session_active, 1'b1)
    rd(REG_STAT, rv);
    `CHK(rv[4:2], 3'h4)
    repeat (1000) @(posedge ref_clk);
    `CHK(session_active, 1'b1)
    repeat (527) @(posedge ref_clk);
    `CHK(session_active, 1'b0)
    rd(REG_STAT, rv);
    `CHK(rv[ST_LOST], 1'b1)
    rd(REG_STAT, rv);
    `CHK(rv[ST_LOST], 1'b0)
    $display("test session done");
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_SID, sid[i]);
      rd(REG_STAT, rv);
      `CHK(rv[ST_ID_OK], ok_exp[i])
    end
    $display("test identifier done");
    report_and_stop();
  end

endmodule : tb
